/* File: hdl/asr_frame_gen.sv */
`timescale 1ns/10ps
`default_nettype none
`include "asr_defs.svh"

module asr_frame_gen #(
	parameter int KEY_W      = 128,
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic             sys_clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic             req_valid_in,
	input  wire logic [1:0]       req_kind_in,
	input  wire logic [7:0]       req_id_in,
	input  wire logic [7:0]       req_code_in,
	input  wire logic [KEY_W-1:0] req_key_in,
	input  wire logic [1:0]       req_src_in,
	input  wire logic [7:0]       req_dest_in,
	input  wire logic [15:0]      req_len_in,
	input  wire logic [2:0]       dest_accept_in,
	output var  logic             req_ready_out,
	input  wire logic             pay_valid_in,
	input  wire logic [7:0]       pay_data_in,
	output var  logic             pay_ready_out,
	output var  logic             tx_valid_out,
	output var  logic [7:0]       tx_data_out,
	input  wire logic             tx_ready_in
);
	asr_pkg::asr_st_type    st_ff;
	asr_pkg::asr_st_type    nxt_st;
	asr_pkg::asr_kind_type  kind;
	asr_pkg::asr_state_type after_fix;
	logic                   acc;
	logic                   can_load;
	logic                   load;
	logic                   add_sum;
	logic [7:0]             byte_out;
	logic                   key_bad;
	logic                   fifo_valid;
	logic [7:0]             fifo_data;
	logic                   fifo_pop;

	if (KEY_W < 8 || FIFO_DEPTH < 2) begin : g_bad_param
		$error("asr_frame_gen needs KEY_W >= 8 and FIFO_DEPTH >= 2");
	end

	// ======================================================================
	// Payload buffer; a full buffer stalls the payload source
	asr_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk_in    (sys_clk_in),
		.sys_rst_in    (sys_rst_in),
		.in_valid_in   (pay_valid_in),
		.in_data_in    (pay_data_in),
		.in_ready_out  (pay_ready_out),
		.out_valid_out (fifo_valid),
		.out_data_out  (fifo_data),
		.out_ready_in  (fifo_pop)
	);

	// ======================================================================
	// Framer
	always_comb begin
		nxt_st = st_ff;
		load = 1'b0;
		add_sum = 1'b0;
		byte_out = 8'h00;
		fifo_pop = 1'b0;
		can_load = !st_ff.tx_valid || tx_ready_in;
		acc = (st_ff.state == asr_pkg::ST_IDLE) && st_ff.req_ready && req_valid_in;
		kind = asr_pkg::asr_kind_type'(req_kind_in);
		key_bad = (req_key_in == '0) || (&req_key_in);
		after_fix = (st_ff.emit && st_ff.cnt != 16'h0000) ? asr_pkg::ST_PAY
			: asr_pkg::ST_CSUM;
		if (tx_ready_in) begin
			nxt_st.tx_valid = 1'b0;
		end
		unique case (st_ff.state)
			asr_pkg::ST_IDLE: begin
				// Port opens one edge after reset; frames and drains open it on the edge they return to idle
				if (!acc) begin
					nxt_st.req_ready = 1'b1;
				end
				if (acc) begin
					nxt_st.req_ready = 1'b0;
					nxt_st.sum = 8'h00;
					nxt_st.cnt = req_len_in;
					nxt_st.has_f4 = 1'b1;
					nxt_st.has_f5 = 1'b1;
					nxt_st.emit = 1'b0;
					nxt_st.f4 = req_id_in;
					nxt_st.len = `ASR_LEN_STAT;
					nxt_st.state = asr_pkg::ST_DELIM;
					unique case (kind)
						asr_pkg::ASR_K_REG: begin
							nxt_st.cnt = 16'h0000;
							nxt_st.ftype = `ASR_T_REG_STAT;
							nxt_st.f5 = key_bad ? `ASR_RS_KEY_BAD : req_code_in;
							if (req_id_in == 8'h00) begin
								nxt_st.state = asr_pkg::ST_IDLE;
								nxt_st.req_ready = 1'b1;
							end
						end
						asr_pkg::ASR_K_UNLOCK: begin
							// Request body is copied back field for field
							nxt_st.ftype = `ASR_T_UNLOCK_RSP;
							nxt_st.has_f4 = 1'b0;
							nxt_st.has_f5 = 1'b0;
							nxt_st.emit = 1'b1;
							nxt_st.len = `ASR_LEN_UNLOCK + req_len_in;
						end
						asr_pkg::ASR_K_RELAY: begin
							nxt_st.ftype = `ASR_T_TX_STAT;
							if (req_dest_in > `ASR_IF_SCRIPT) begin
								nxt_st.f5 = `ASR_ERR_NO_IF;
							end else if (!dest_accept_in[req_dest_in[1:0]]) begin
								nxt_st.f5 = `ASR_ERR_IF_BUSY;
							end else if (req_dest_in == `ASR_IF_SERIAL) begin
								nxt_st.ftype = `ASR_T_RELAY_OUT;
								nxt_st.f4 = {6'h00, req_src_in};
								nxt_st.has_f5 = 1'b0;
								nxt_st.emit = 1'b1;
								nxt_st.len = `ASR_LEN_RELAY + req_len_in;
							end else begin
								// Delivered elsewhere: silent, only the payload is taken
								nxt_st.state = (req_len_in != 16'h0000) ? asr_pkg::ST_DRAIN
									: asr_pkg::ST_IDLE;
								nxt_st.req_ready = (req_len_in == 16'h0000);
							end
						end
						asr_pkg::ASR_K_SPARE: begin
							nxt_st.state = asr_pkg::ST_IDLE;
							nxt_st.req_ready = 1'b1;
						end
					endcase
				end
			end
			asr_pkg::ST_DELIM: begin
				load = can_load;
				byte_out = `ASR_DELIM;
				if (can_load) begin
					nxt_st.state = asr_pkg::ST_LEN_HI;
				end
			end
			asr_pkg::ST_LEN_HI: begin
				load = can_load;
				byte_out = st_ff.len[15:8];
				if (can_load) begin
					nxt_st.state = asr_pkg::ST_LEN_LO;
				end
			end
			asr_pkg::ST_LEN_LO: begin
				load = can_load;
				byte_out = st_ff.len[7:0];
				if (can_load) begin
					nxt_st.state = asr_pkg::ST_TYPE;
				end
			end
			asr_pkg::ST_TYPE: begin
				load = can_load;
				add_sum = 1'b1;
				byte_out = st_ff.ftype;
				if (can_load) begin
					nxt_st.state = st_ff.has_f4 ? asr_pkg::ST_F4 : after_fix;
				end
			end
			asr_pkg::ST_F4: begin
				load = can_load;
				add_sum = 1'b1;
				byte_out = st_ff.f4;
				if (can_load) begin
					nxt_st.state = st_ff.has_f5 ? asr_pkg::ST_F5 : after_fix;
				end
			end
			asr_pkg::ST_F5: begin
				load = can_load;
				add_sum = 1'b1;
				byte_out = st_ff.f5;
				if (can_load) begin
					nxt_st.state = after_fix;
				end
			end
			asr_pkg::ST_PAY: begin
				// Stall on an empty buffer rather than emit a short frame
				load = can_load && fifo_valid;
				add_sum = 1'b1;
				byte_out = fifo_data;
				if (load) begin
					fifo_pop = 1'b1;
					nxt_st.cnt = st_ff.cnt - 16'h0001;
					if (st_ff.cnt == 16'h0001) begin
						nxt_st.state = asr_pkg::ST_CSUM;
					end
				end
			end
			asr_pkg::ST_CSUM: begin
				load = can_load;
				byte_out = `ASR_CSUM_BASE - st_ff.sum;
				if (can_load) begin
					nxt_st.state = (st_ff.cnt != 16'h0000) ? asr_pkg::ST_DRAIN
						: asr_pkg::ST_IDLE;
					nxt_st.req_ready = (st_ff.cnt == 16'h0000);
				end
			end
			asr_pkg::ST_DRAIN: begin
				// Failed or forwarded relay: its payload is discarded
				fifo_pop = fifo_valid;
				if (fifo_valid) begin
					nxt_st.cnt = st_ff.cnt - 16'h0001;
					if (st_ff.cnt == 16'h0001) begin
						nxt_st.state = asr_pkg::ST_IDLE;
						nxt_st.req_ready = 1'b1;
					end
				end
			end
			default: begin
				nxt_st.state = asr_pkg::ST_IDLE;
				nxt_st.req_ready = 1'b1;
			end
		endcase
		if (load) begin
			nxt_st.tx_valid = 1'b1;
			nxt_st.tx_data = byte_out;
			if (add_sum) begin
				nxt_st.sum = st_ff.sum + byte_out;
			end
		end
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign req_ready_out = st_ff.req_ready;
	assign tx_valid_out  = st_ff.tx_valid;
	assign tx_data_out   = st_ff.tx_data;

	// ======================================================================
	// Checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);

	a_reg_zero_id: assert property (
		acc && kind == asr_pkg::ASR_K_REG && req_id_in == 8'h00
		|=> st_ff.state == asr_pkg::ST_IDLE && st_ff.req_ready)
		else $error("status frame started for zero id");
	a_reg_answer_fields: assert property (
		acc && kind == asr_pkg::ASR_K_REG && req_id_in != 8'h00 && !key_bad
		|=> st_ff.ftype == `ASR_T_REG_STAT && st_ff.f4 == $past(req_id_in)
		&& st_ff.f5 == $past(req_code_in) && st_ff.len == `ASR_LEN_STAT)
		else $error("registration status fields wrong");
	a_key_reserved: assert property (
		acc && kind == asr_pkg::ASR_K_REG && req_id_in != 8'h00
		&& (req_key_in == {KEY_W{1'b0}} || req_key_in == {KEY_W{1'b1}})
		|=> st_ff.f5 == `ASR_RS_KEY_BAD)
		else $error("reserved key not refused");
	a_frame_opening: assert property (
		st_ff.state == asr_pkg::ST_DELIM && can_load
		|=> tx_valid_out && tx_data_out == `ASR_DELIM
		##1 (!$past(tx_ready_in) || tx_data_out == st_ff.len[15:8]))
		else $error("frame does not open with delimiter and length");
	a_csum_value: assert property (
		st_ff.state == asr_pkg::ST_CSUM && can_load
		|=> 8'(tx_data_out + $past(st_ff.sum)) == `ASR_CSUM_BASE)
		else $error("checksum byte wrong");
	a_unlock_echo: assert property (
		acc && kind == asr_pkg::ASR_K_UNLOCK
		|=> st_ff.ftype == `ASR_T_UNLOCK_RSP && !st_ff.has_f4 && st_ff.emit)
		else $error("unlock response not built from request");
	a_relay_header: assert property (
		acc && kind == asr_pkg::ASR_K_RELAY && req_dest_in == `ASR_IF_SERIAL
		&& dest_accept_in[0]
		|=> st_ff.ftype == `ASR_T_RELAY_OUT && st_ff.f4 == {6'h00, $past(req_src_in)})
		else $error("relay frame header wrong");
	a_payload_order: assert property (
		st_ff.state == asr_pkg::ST_PAY && load
		|=> tx_valid_out && tx_data_out == $past(fifo_data))
		else $error("payload byte altered");
	a_bad_dest_code: assert property (
		acc && kind == asr_pkg::ASR_K_RELAY && req_dest_in > `ASR_IF_SCRIPT
		|=> st_ff.ftype == `ASR_T_TX_STAT && st_ff.f5 == `ASR_ERR_NO_IF)
		else $error("missing destination not reported");
	a_busy_dest_code: assert property (
		acc && kind == asr_pkg::ASR_K_RELAY && req_dest_in <= `ASR_IF_SCRIPT
		&& !dest_accept_in[req_dest_in[1:0]]
		|=> st_ff.f5 == `ASR_ERR_IF_BUSY && st_ff.state == asr_pkg::ST_DELIM)
		else $error("busy destination not reported");
	a_relay_quiet: assert property (
		acc && kind == asr_pkg::ASR_K_RELAY && req_dest_in != `ASR_IF_SERIAL
		&& req_dest_in <= `ASR_IF_SCRIPT && dest_accept_in[req_dest_in[1:0]]
		|=> st_ff.state inside {asr_pkg::ST_IDLE, asr_pkg::ST_DRAIN})
		else $error("status frame after successful relay");

	c_reg_frame: cover property (acc && kind == asr_pkg::ASR_K_REG ##[1:20]
		st_ff.state == asr_pkg::ST_CSUM);
	c_relay_frame: cover property (st_ff.ftype == `ASR_T_RELAY_OUT
		&& st_ff.state == asr_pkg::ST_PAY ##1 st_ff.state == asr_pkg::ST_PAY);
	c_relay_error: cover property (acc && kind == asr_pkg::ASR_K_RELAY
		&& req_dest_in > `ASR_IF_SCRIPT);
	c_fifo_stall: cover property (!pay_ready_out && pay_valid_in);

endmodule // asr_frame_gen

`default_nettype wire

/* File: include/asr_defs.svh */
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

// ==========================================================================
// Frame framing
`define ASR_DELIM        8'h7e
`define ASR_CSUM_BASE    8'hff

// ==========================================================================
// Frame type codes
`define ASR_T_REG_REQ    8'h24
`define ASR_T_REG_STAT   8'ha4
`define ASR_T_UNLOCK_REQ 8'h2c
`define ASR_T_UNLOCK_RSP 8'hac
`define ASR_T_RELAY_OUT  8'had
`define ASR_T_TX_STAT    8'h89

// ==========================================================================
// Registration outcome codes
`define ASR_RS_OK        8'h00
`define ASR_RS_KEY_LONG  8'h01
`define ASR_RS_TRANS_FUL 8'h18
`define ASR_RS_NO_ADDR   8'hb1
`define ASR_RS_KEY_BAD   8'hb2
`define ASR_RS_BAD_ADDR  8'hb3
`define ASR_RS_TAB_FULL  8'hb4
`define ASR_RS_SEC_BAD   8'hbd

// ==========================================================================
// Relay interfaces and error codes
`define ASR_IF_SERIAL    8'h00
`define ASR_IF_WIRELESS  8'h01
`define ASR_IF_SCRIPT    8'h02
`define ASR_ERR_NO_IF    8'h7c
`define ASR_ERR_IF_BUSY  8'h7d

// ==========================================================================
// Length field: bytes between length and checksum, before payload
`define ASR_LEN_STAT     16'h0003
`define ASR_LEN_UNLOCK   16'h0001
`define ASR_LEN_RELAY    16'h0002

`endif

/* File: include/asr_pkg.sv */
`default_nettype none

package asr_pkg;

	// ======================================================================
	// Request kinds on the request port
	typedef enum logic [1:0] {
		ASR_K_REG,
		ASR_K_UNLOCK,
		ASR_K_RELAY,
		ASR_K_SPARE
	} asr_kind_type;

	// ======================================================================
	// Framer states, one per emitted field, plus idle and payload drain
	typedef enum logic [3:0] {
		ST_IDLE, ST_DELIM, ST_LEN_HI, ST_LEN_LO, ST_TYPE,
		ST_F4, ST_F5, ST_PAY, ST_CSUM, ST_DRAIN
	} asr_state_type;

	// ======================================================================
	// Whole framer state
	typedef struct packed {
		asr_state_type state;
		logic          req_ready;
		logic          tx_valid;
		logic [7:0]    tx_data;
		logic [7:0]    ftype;
		logic [7:0]    f4;
		logic [7:0]    f5;
		logic          has_f4;
		logic          has_f5;
		logic          emit;
		logic [15:0]   len;
		logic [15:0]   cnt;
		logic [7:0]    sum;
	} asr_st_type;

endpackage

`default_nettype wire

/* File: hdl/asr_fifo.sv */
`timescale 1ns/10ps
`default_nettype none

module asr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             sys_clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output var  logic             in_ready_out,
	output var  logic             out_valid_out,
	output var  logic [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wptr;
		logic [AW-1:0]               rptr;
		logic [AW:0]                 count;
		logic                        in_ready;
	} asr_fifo_st_type;

	asr_fifo_st_type st_ff;
	asr_fifo_st_type nxt_st;
	logic            push;
	logic            pop;

	if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
		$error("asr_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
	end

	// ======================================================================
	// Pointers wrap by compare, so DEPTH need not be a power of two
	always_comb begin
		nxt_st = st_ff;
		push = in_valid_in && st_ff.in_ready;
		pop = out_ready_in && (st_ff.count != '0);
		if (push) begin
			nxt_st.mem[st_ff.wptr] = in_data_in;
			nxt_st.wptr = (st_ff.wptr == AW'(DEPTH - 1)) ? '0 : st_ff.wptr + AW'(1);
		end
		if (pop) begin
			nxt_st.rptr = (st_ff.rptr == AW'(DEPTH - 1)) ? '0 : st_ff.rptr + AW'(1);
		end
		nxt_st.count = st_ff.count + (AW+1)'(push) - (AW+1)'(pop);
		// Registered ready keeps the source's stall path short
		nxt_st.in_ready = (nxt_st.count != (AW+1)'(DEPTH));
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign in_ready_out  = st_ff.in_ready;
	assign out_valid_out = (st_ff.count != '0);
	assign out_data_out  = st_ff.mem[st_ff.rptr];

endmodule // asr_fifo

`default_nettype wire

/* File: hdl/asr_fix_note.sv */
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* File: verification/asr_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

module asr_host_model (
	input  wire logic       sys_clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       slow_in,
	input  wire logic       tx_valid_in,
	input  wire logic [7:0] tx_data_in,
	output var  logic       tx_ready_out
);
	// ======================================================================
	// Serial byte sink
	logic [7:0] rx_q[$];
	logic [1:0] phase_ff;

	// Slow mode takes one byte in three, so the framer must hold its byte
	always @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			phase_ff     <= 2'h0;
			tx_ready_out <= 1'b0;
		end else begin
			if (tx_valid_in && tx_ready_out) begin
				rx_q.push_back(tx_data_in);
			end
			phase_ff     <= (phase_ff == 2'h2) ? 2'h0 : phase_ff + 2'h1;
			tx_ready_out <= !slow_in || (phase_ff == 2'h1);
		end
	end
endmodule // asr_host_model

`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/10ps
`default_nettype none

module tb;
	localparam int KW = 128;
	localparam logic [KW-1:0] KEY = {16{8'h3c}};

	// ======================================================================
	// Stimulus and observation
	logic          sys_clk_in     = 1'b0;
	logic          sys_rst_in     = 1'b1;
	logic          req_valid_in   = 1'b0;
	logic [1:0]    req_kind_in    = 2'h0;
	logic [7:0]    req_id_in      = 8'h00;
	logic [7:0]    req_code_in    = 8'h00;
	logic [KW-1:0] req_key_in     = '0;
	logic [1:0]    req_src_in     = 2'h0;
	logic [7:0]    req_dest_in    = 8'h00;
	logic [15:0]   req_len_in     = 16'h0000;
	logic [2:0]    dest_accept_in = 3'h7;
	logic          pay_valid_in   = 1'b0;
	logic [7:0]    pay_data_in    = 8'h00;
	logic          slow           = 1'b0;
	logic          saw_full       = 1'b0;
	logic          req_ready_out;
	logic          pay_ready_out;
	logic          tx_valid_out;
	logic [7:0]    tx_data_out;
	logic          tx_ready;
	int            n_mismatch     = 0;
	int            total_checks   = 0;
	int            cyc            = 0;

	always #5 sys_clk_in = ~sys_clk_in;

	asr_frame_gen #(.KEY_W(KW), .FIFO_DEPTH(8)) dut (
		.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
		.req_valid_in(req_valid_in), .req_kind_in(req_kind_in),
		.req_id_in(req_id_in), .req_code_in(req_code_in), .req_key_in(req_key_in),
		.req_src_in(req_src_in), .req_dest_in(req_dest_in), .req_len_in(req_len_in),
		.dest_accept_in(dest_accept_in), .req_ready_out(req_ready_out),
		.pay_valid_in(pay_valid_in), .pay_data_in(pay_data_in),
		.pay_ready_out(pay_ready_out), .tx_valid_out(tx_valid_out),
		.tx_data_out(tx_data_out), .tx_ready_in(tx_ready)
	);

	asr_host_model host (
		.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .slow_in(slow),
		.tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out), .tx_ready_out(tx_ready)
	);

	// ======================================================================
	// Shared tasks
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Request held until taken at a rising edge with ready high
	task automatic req(input logic [1:0] k, input logic [7:0] id, code, dest,
		input logic [2:0] acc, input logic [1:0] src, input logic [15:0] len,
		input logic [KW-1:0] key = KEY);
		int i;
		@(negedge sys_clk_in);
		{req_kind_in, req_id_in, req_code_in, req_dest_in} = {k, id, code, dest};
		{dest_accept_in, req_src_in, req_len_in, req_key_in} = {acc, src, len, key};
		req_valid_in = 1'b1;
		for (i = 0; i < 300 && req_ready_out !== 1'b1; i++) @(negedge sys_clk_in);
		check("req_ready", 16'h1, {15'h0, req_ready_out});
		@(negedge sys_clk_in);
		req_valid_in = 1'b0;
	endtask

	task automatic pay(input logic [7:0] b[$]);
		int i;
		foreach (b[j]) begin
			@(negedge sys_clk_in);
			pay_data_in  = b[j];
			pay_valid_in = 1'b1;
			for (i = 0; i < 300 && pay_ready_out !== 1'b1; i++) begin
				saw_full = 1'b1;
				@(negedge sys_clk_in);
			end
		end
		@(negedge sys_clk_in);
		pay_valid_in = 1'b0;
	endtask

	// Expected bytes are built from the framing rules, not from the design
	task automatic frame(input logic [7:0] t, input logic [7:0] b[$]);
		logic [7:0]  e[$];
		logic [7:0]  s;
		logic [15:0] ln;
		int          i;
		ln = 16'(b.size() + 1);
		e = {8'h7e, ln[15:8], ln[7:0], t};
		s = t;
		foreach (b[j]) begin
			e.push_back(b[j]);
			s = s + b[j];
		end
		e.push_back(8'hff - s);
		for (i = 0; i < 2000 && host.rx_q.size() < e.size(); i++) @(negedge sys_clk_in);
		foreach (e[j]) begin
			if (host.rx_q.size() > 0) begin
				check("frame_byte", {8'h0, e[j]}, {8'h0, host.rx_q.pop_front()});
			end else begin
				check("frame_byte", {8'h0, e[j]}, 16'hxxxx);
			end
		end
	endtask

	task automatic quiet();
		repeat (40) @(negedge sys_clk_in);
		check("no_output", 16'h0, 16'(host.rx_q.size()));
		check("ready_back", 16'h1, {15'h0, req_ready_out});
	endtask

	// ======================================================================
	// Scenarios
	task automatic t_reg();
		logic [7:0] c[7] = '{8'h00, 8'h01, 8'h18, 8'hb1, 8'hb3, 8'hb4, 8'hbd};
		for (int i = 0; i < 7; i++) begin
			req(2'h0, 8'h5d + 8'(i), c[i], 8'h00, 3'h7, 2'h0, 16'h0);
			frame(8'ha4, {8'h5d + 8'(i), c[i]});
		end
	endtask

	task automatic t_key();
		for (int i = 0; i < 2; i++) begin
			req(2'h0, 8'h21, 8'h00, 8'h00, 3'h7, 2'h0, 16'h0,
				(i == 0) ? {KW{1'b0}} : {KW{1'b1}});
			frame(8'ha4, {8'h21, 8'hb2});
		end
	endtask

	task automatic t_zero_id();
		req(2'h0, 8'h00, 8'h00, 8'h00, 3'h7, 2'h0, 16'h0);
		quiet();
		// Spare request kind is taken and answered by nothing
		req(2'h3, 8'h33, 8'h00, 8'h00, 3'h7, 2'h0, 16'h0);
		quiet();
	endtask

	task automatic t_unlock();
		fork
			req(2'h1, 8'h00, 8'h00, 8'h00, 3'h7, 2'h0, 16'h3);
			pay({8'h11, 8'h22, 8'h33});
		join
		frame(8'hac, {8'h11, 8'h22, 8'h33});
	endtask

	task automatic t_relay();
		for (int s = 0; s < 3; s++) begin
			fork
				req(2'h2, 8'h40, 8'h00, 8'h00, 3'h7, 2'(s), 16'h2);
				pay({8'ha0 + 8'(s), 8'h0f});
			join
			frame(8'had, {8'(s), 8'ha0 + 8'(s), 8'h0f});
		end
		// Sink stalls so the payload buffer must fill and refuse
		slow = 1'b1;
		saw_full = 1'b0;
		fork
			req(2'h2, 8'h41, 8'h00, 8'h00, 3'h7, 2'h1, 16'ha);
			pay({8'h52, 8'h65, 8'h6c, 8'h61, 8'h79, 8'h20, 8'h44, 8'h61, 8'h74, 8'h61});
		join
		frame(8'had, {8'h01, 8'h52, 8'h65, 8'h6c, 8'h61, 8'h79, 8'h20, 8'h44, 8'h61,
			8'h74, 8'h61});
		check("buffer_full", 16'h1, {15'h0, saw_full});
		slow = 1'b0;
	endtask

	task automatic t_relay_err();
		logic [7:0] d[3] = '{8'h03, 8'h01, 8'h00};
		logic [2:0] a[3] = '{3'h7, 3'h5, 3'h6};
		logic [7:0] c[3] = '{8'h7c, 8'h7d, 8'h7d};
		for (int i = 0; i < 3; i++) begin
			fork
				req(2'h2, 8'h60 + 8'(i), 8'h00, d[i], a[i], 2'h1, 16'h2);
				pay({8'hee, 8'hdd});
			join
			frame(8'h89, {8'h60 + 8'(i), c[i]});
		end
		quiet();
	endtask

	task automatic t_relay_ok();
		fork
			req(2'h2, 8'h70, 8'h00, 8'h02, 3'h7, 2'h0, 16'h3);
			pay({8'h01, 8'h02, 8'h03});
		join
		quiet();
		req(2'h0, 8'h71, 8'h00, 8'h00, 3'h7, 2'h0, 16'h0);
		frame(8'ha4, {8'h71, 8'h00});
	endtask

	// ======================================================================
	// Main sequence and hang guard
	always @(posedge sys_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	initial begin
		repeat (3) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		check("tx_valid_rst", 16'h0, {15'h0, tx_valid_out});
		sys_rst_in = 1'b0;
		t_reg();
		t_key();
		t_zero_id();
		t_unlock();
		t_relay();
		t_relay_err();
		t_relay_ok();
		stop_test();
	end
endmodule // tb

`default_nettype wire
